/* File: rx_fmt_pkg.sv */
/*
 * Constants for the receive parallel output formatter.
 * Assumes a 10-bit character stream with decoded byte and status supplied upstream.
 */
package rx_fmt_pkg;
    // ------------------------------------------------------------
    // widths and field positions
    // ------------------------------------------------------------
    localparam int DATA_W      = 8;
    localparam int STAT_W      = 3;
    localparam int RAW_W       = 10;
    localparam int RAW_HI_MSB  = 9;
    localparam int RAW_HI_LSB  = 2;
    localparam int RAW_LO_MSB  = 1;
    localparam int RAW_LO_LSB  = 0;
    localparam int COMMA_BIT   = 2;

    // ------------------------------------------------------------
    // mode encoding of the three-level decoder select
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DEC_LOW  = 2'h0,
        DEC_MID  = 2'h1,
        DEC_HIGH = 2'h2
    } dec_level_t;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
    localparam logic [1:0]        SYNC_RST = 2'h0;

    // ------------------------------------------------------------
    // output stage states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RESET = 2'h1,
        ST_RUN   = 2'h2
    } out_state_t;
endpackage

/* File: rx_parallel_output_formatter.sv */
/*
 * Receive output register of one channel: formats each character strobed in ST_RUN onto the
 * parallel data and status buses.
 * Assumes the character and its strobe arrive synchronous to out_clk_in;
 * the selected interface clock is muxed outside and given as out_clk_in.
 */
`timescale 1ns/1ns
module rx_parallel_output_formatter
(
    input  wire logic                               clk_in,
    input  wire logic                               srst_in,
    input  wire logic                               out_clk_in,
    input  wire logic                               out_srst_in,
    input  wire logic [1:0]                         decoder_mode_sel_in,
    input  wire logic                               char_valid_in,
    input  wire logic [rx_fmt_pkg::RAW_W-1:0]       raw_char_in,
    input  wire logic [rx_fmt_pkg::DATA_W-1:0]      dec_char_in,
    input  wire logic [rx_fmt_pkg::STAT_W-1:0]      dec_status_in,
    input  wire logic                               comma_in,
    output logic      [rx_fmt_pkg::DATA_W-1:0]      rx_char_data_out,
    output logic      [rx_fmt_pkg::STAT_W-1:0]      rx_char_status_out,
    output logic                                    mode_bypass_out
);
    // ------------------------------------------------------------
    // mode select synchroniser (static pin into clk_in domain)
    // ------------------------------------------------------------
    logic [1:0] mode_s1_reg;
    logic [1:0] mode_s1_next;
    logic [1:0] mode_s2_reg;
    logic [1:0] mode_s2_next;
    logic       bypass_reg;
    logic       bypass_next;

    always_comb
    begin
        mode_s1_next = decoder_mode_sel_in;
        mode_s2_next = mode_s1_reg;
        bypass_next  = (mode_s2_reg == rx_fmt_pkg::DEC_LOW);
    end

    always_ff @(posedge clk_in)
    begin
        if (srst_in)
        begin
            mode_s1_reg <= rx_fmt_pkg::SYNC_RST;
            mode_s2_reg <= rx_fmt_pkg::SYNC_RST;
            bypass_reg  <= 1'b0;
        end
        else
        begin
            mode_s1_reg <= mode_s1_next;
            mode_s2_reg <= mode_s2_next;
            bypass_reg  <= bypass_next;
        end
    end

    assign mode_bypass_out = bypass_reg;

    // ------------------------------------------------------------
    // bypass level crossed into the output clock domain
    // ------------------------------------------------------------
    logic byp_o1_reg;
    logic byp_o1_next;
    logic byp_o2_reg;
    logic byp_o2_next;

    always_comb
    begin
        byp_o1_next = bypass_reg;
        byp_o2_next = byp_o1_reg;
    end

    always_ff @(posedge out_clk_in)
    begin
        if (out_srst_in)
        begin
            byp_o1_reg <= 1'b0;
            byp_o2_reg <= 1'b0;
        end
        else
        begin
            byp_o1_reg <= byp_o1_next;
            byp_o2_reg <= byp_o2_next;
        end
    end

    // ------------------------------------------------------------
    // character formatting for the current mode
    // ------------------------------------------------------------
    logic [rx_fmt_pkg::DATA_W-1:0]          fmt_data;
    logic [rx_fmt_pkg::STAT_W-1:0]          fmt_stat;

    // bypass splits the raw character, decoder passes byte and status
    always_comb
    begin
        fmt_data = dec_char_in;
        fmt_stat = dec_status_in;
        if (byp_o2_reg)
        begin
            fmt_data = raw_char_in[rx_fmt_pkg::RAW_HI_MSB:
                                   rx_fmt_pkg::RAW_HI_LSB];
            fmt_stat[rx_fmt_pkg::RAW_LO_MSB:rx_fmt_pkg::RAW_LO_LSB] =
                raw_char_in[rx_fmt_pkg::RAW_LO_MSB:
                            rx_fmt_pkg::RAW_LO_LSB];
            fmt_stat[rx_fmt_pkg::COMMA_BIT] = comma_in;
        end
    end

    // ------------------------------------------------------------
    // output register, state and formatting
    // ------------------------------------------------------------
    rx_fmt_pkg::out_state_t                 state_reg;
    rx_fmt_pkg::out_state_t                 state_next;
    logic [rx_fmt_pkg::DATA_W-1:0]          data_reg;
    logic [rx_fmt_pkg::DATA_W-1:0]          data_next;
    logic [rx_fmt_pkg::STAT_W-1:0]          stat_reg;
    logic [rx_fmt_pkg::STAT_W-1:0]          stat_next;

    always_comb
    begin
        state_next = state_reg;
        data_next  = data_reg;
        stat_next  = stat_reg;
        case (state_reg)
            rx_fmt_pkg::ST_RESET:
            begin
                state_next = rx_fmt_pkg::ST_RUN;
            end
            rx_fmt_pkg::ST_RUN:
            begin
                // a character is taken only with its strobe
                if (char_valid_in)
                begin
                    data_next = fmt_data;
                    stat_next = fmt_stat;
                end
            end
            default:
            begin
                state_next = rx_fmt_pkg::ST_RESET;
            end
        endcase
    end

    // updates only on the rising edge of the selected clock
    always_ff @(posedge out_clk_in)
    begin
        if (out_srst_in)
        begin
            state_reg <= rx_fmt_pkg::ST_RESET;
            data_reg  <= rx_fmt_pkg::DATA_RST;
            stat_reg  <= rx_fmt_pkg::STAT_RST;
        end
        else
        begin
            state_reg <= state_next;
            data_reg  <= data_next;
            stat_reg  <= stat_next;
        end
    end

    assign rx_char_data_out   = data_reg;
    assign rx_char_status_out = stat_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_BYP_DATA: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        (state_reg == rx_fmt_pkg::ST_RUN && char_valid_in && byp_o2_reg)
        |=> rx_char_data_out ==
            $past(raw_char_in[rx_fmt_pkg::RAW_HI_MSB:rx_fmt_pkg::RAW_HI_LSB]))
        else $error("bypass data not upper raw bits");
    AST_BYP_LOW: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        (state_reg == rx_fmt_pkg::ST_RUN && char_valid_in && byp_o2_reg)
        |=> rx_char_status_out[rx_fmt_pkg::RAW_LO_MSB:rx_fmt_pkg::RAW_LO_LSB] ==
            $past(raw_char_in[rx_fmt_pkg::RAW_LO_MSB:rx_fmt_pkg::RAW_LO_LSB]))
        else $error("bypass status low bits wrong");
    AST_BYP_COMMA: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        (state_reg == rx_fmt_pkg::ST_RUN && char_valid_in && byp_o2_reg)
        |=> rx_char_status_out[2] == $past(comma_in))
        else $error("comma flag wrong");
    AST_DEC_DATA: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        (state_reg == rx_fmt_pkg::ST_RUN && char_valid_in && !byp_o2_reg)
        |=> rx_char_data_out == $past(dec_char_in))
        else $error("decoded data wrong");
    AST_DEC_STAT: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        (state_reg == rx_fmt_pkg::ST_RUN && char_valid_in && !byp_o2_reg)
        |=> rx_char_status_out == $past(dec_status_in))
        else $error("decoded status wrong");
    AST_HOLD: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        !char_valid_in |=> $stable(rx_char_data_out) && $stable(rx_char_status_out))
        else $error("outputs changed without a character");

    // ------------------------------------------------------------
    // checks: mode select path
    // ------------------------------------------------------------
    AST_MODE_CHAIN: assert property (@(posedge clk_in) disable iff (srst_in)
        !$past(srst_in)
        |->
        mode_s2_reg == $past(mode_s1_reg))
        else $error("mode synchroniser chain broken");

    AST_BYPASS_FLAG: assert property (@(posedge clk_in) disable iff (srst_in)
        !$past(srst_in)
        |->
        bypass_reg == $past(mode_s2_reg == rx_fmt_pkg::DEC_LOW))
        else $error("bypass flag does not follow the mode select");

    AST_BYP_FIRST: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        !$past(out_srst_in)
        |->
        byp_o1_reg == $past(bypass_reg))
        else $error("bypass crossing first stage wrong");

    AST_BYP_CROSS: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        !$past(out_srst_in)
        |->
        byp_o2_reg == $past(byp_o1_reg))
        else $error("bypass crossing second stage wrong");

    // ------------------------------------------------------------
    // checks: reset and first edge
    // ------------------------------------------------------------
    AST_RST_DATA: assert property (@(posedge out_clk_in)
        out_srst_in
        |=>
        rx_char_data_out == rx_fmt_pkg::DATA_RST)
        else $error("data not cleared by reset");

    AST_RST_STAT: assert property (@(posedge out_clk_in)
        out_srst_in
        |=>
        rx_char_status_out == rx_fmt_pkg::STAT_RST)
        else $error("status not cleared by reset");

    AST_RST_STATE: assert property (@(posedge out_clk_in)
        out_srst_in
        |=>
        state_reg == rx_fmt_pkg::ST_RESET)
        else $error("state not reset");

    AST_RST_BYPASS: assert property (@(posedge clk_in)
        srst_in
        |=>
        !mode_bypass_out)
        else $error("bypass flag not cleared by reset");

    AST_FIRST_EDGE: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        state_reg == rx_fmt_pkg::ST_RESET
        |=>
        state_reg == rx_fmt_pkg::ST_RUN)
        else $error("dead state not left after one edge");

    AST_REFUSE_DATA: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        state_reg == rx_fmt_pkg::ST_RESET
        |=>
        rx_char_data_out == rx_fmt_pkg::DATA_RST)
        else $error("character taken in the dead state");

    AST_REFUSE_STAT: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        state_reg == rx_fmt_pkg::ST_RESET
        |=>
        rx_char_status_out == rx_fmt_pkg::STAT_RST)
        else $error("status taken in the dead state");

    // ------------------------------------------------------------
    // checks: output stage
    // ------------------------------------------------------------
    AST_STATE_ONEHOT: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        $onehot(state_reg))
        else $error("state code not one-hot");

    AST_STATE_RUN: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        state_reg == rx_fmt_pkg::ST_RUN
        |=>
        state_reg == rx_fmt_pkg::ST_RUN)
        else $error("running state left without reset");

    AST_DATA_SRC: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        !$past(out_srst_in) && $changed(rx_char_data_out)
        |->
        $past(char_valid_in) && $past(state_reg) == rx_fmt_pkg::ST_RUN)
        else $error("data changed without a taken character");

    AST_STAT_SRC: assert property (@(posedge out_clk_in) disable iff (out_srst_in)
        !$past(out_srst_in) && $changed(rx_char_status_out)
        |->
        $past(char_valid_in) && $past(state_reg) == rx_fmt_pkg::ST_RUN)
        else $error("status changed without a taken character");
endmodule // rx_parallel_output_formatter

/* File: host_latch.sv */
/*
 * Host-side model: latches the parallel buses on the selected clock.
 * Assumes out_clk_in is the same clock that drives the formatter outputs.
 */
`timescale 1ns/1ns
module host_latch
(
    input  wire logic       out_clk_in,
    input  wire logic [7:0] data_in,
    input  wire logic [2:0] status_in,
    output logic      [7:0] latched_data_out,
    output logic      [2:0] latched_status_out
);
    // host takes the character on the rising edge
    always_ff @(posedge out_clk_in)
    begin
        latched_data_out   <= data_in;
        latched_status_out <= status_in;
    end
endmodule // host_latch

/* File: testbench.sv */
/*
 * Bench for the receive output formatter: both clock domains, both modes.
 * Assumes host_latch and rx_fmt_pkg are compiled first.
 */
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
    logic       clk_in      = 1'b0;
    logic       out_clk_in  = 1'b0;
    logic       srst_in     = 1'b1;
    logic       out_srst_in = 1'b1;
    logic [1:0] mode        = 2'h0;
    logic       valid       = 1'b0;
    logic [9:0] raw         = 10'h000;
    logic [7:0] dec         = 8'h00;
    logic [2:0] st          = 3'h0;
    logic       comma       = 1'b0;
    logic [7:0] data;
    logic [2:0] stat;
    logic       byp;
    logic [7:0] h_data;
    logic [2:0] h_stat;
    int         fail_count  = 0;
    int         checks_done = 0;
    initial forever #50 clk_in = ~clk_in;
    initial
    begin
        #37;
        forever
        begin
            #62 out_clk_in = ~out_clk_in;
            #63 out_clk_in = ~out_clk_in;
        end
    end
    rx_parallel_output_formatter dut (.clk_in(clk_in), .srst_in(srst_in),
        .out_clk_in(out_clk_in), .out_srst_in(out_srst_in), .decoder_mode_sel_in(mode),
        .char_valid_in(valid), .raw_char_in(raw), .dec_char_in(dec), .dec_status_in(st),
        .comma_in(comma), .rx_char_data_out(data), .rx_char_status_out(stat),
        .mode_bypass_out(byp));
    host_latch host (.out_clk_in(out_clk_in), .data_in(data), .status_in(stat),
        .latched_data_out(h_data), .latched_status_out(h_stat));
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic set_mode(input logic [1:0] m);
        @(negedge clk_in) mode = m;
        repeat (8) @(negedge out_clk_in);
    endtask
    // one character, then inputs flip to their inverse with valid low
    task automatic send(input logic [9:0] r, input logic [7:0] d,
                        input logic [2:0] s, input logic c);
        @(negedge out_clk_in);
        {raw, dec, st, comma, valid} = {r, d, s, c, 1'b1};
        @(negedge out_clk_in);
        {raw, dec, st, comma, valid} = {~r, ~d, ~s, ~c, 1'b0};
    endtask
    // outputs stand between characters and match what the host latched
    task automatic hold_check(input logic [7:0] ed, input logic [2:0] es);
        repeat (3) @(negedge out_clk_in);
        `CHK("hold data", ed, data)
        `CHK("hold status", es, stat)
        `CHK("host data", ed, h_data)
        `CHK("host status", es, h_stat)
    endtask
    task automatic test_bypass();
        logic [9:0] r;
        set_mode(rx_fmt_pkg::DEC_LOW);
        `CHK("bypass flag", 1'b1, byp)
        for (int i = 0; i < 4; i++)
        begin
            r = (i < 2) ? 10'h2B5 : 10'h14A;
            send(r, 8'h3C, 3'h2, i[0]);
            `CHK("raw high", r[9:2], data)
            `CHK("raw low", r[1:0], stat[1:0])
            `CHK("comma", i[0], stat[2])
            hold_check(r[9:2], {i[0], r[1:0]});
        end
    endtask
    task automatic test_decoded();
        logic [1:0] m [2] = '{rx_fmt_pkg::DEC_MID, rx_fmt_pkg::DEC_HIGH};
        for (int i = 0; i < 2; i++)
        begin
            set_mode(m[i]);
            `CHK("bypass flag", 1'b0, byp)
            send(10'h3FF, 8'hA5 ^ 8'(i), 3'h5 ^ 3'(i), 1'b1);
            `CHK("decoded data", 8'hA5 ^ 8'(i), data)
            `CHK("decoded status", 3'h5 ^ 3'(i), stat)
            hold_check(8'hA5 ^ 8'(i), 3'h5 ^ 3'(i));
        end
    endtask
    initial
    begin
        repeat (8) @(negedge clk_in);
        srst_in = 1'b0;
        @(negedge out_clk_in) out_srst_in = 1'b0;
        `CHK("reset data", 8'h00, data)
        test_bypass();
        test_decoded();
        final_report();
    end
    initial
    begin
        #2000000;
        fail_count++;
        final_report();
    end
endmodule // testbench
